// ==== tsr_stage_regs.sv ====
// Identification, proximity status and per-stage routing registers
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - A read-only identification word at 0x017 holds revision zero in bits 3:0 and the part code in bits 15:4.
// - A read-only word at 0x042 shows in bit n the proximity flag of stage n for stages 0 to 11, zero after reset.
// - Each of the twelve stages has its own low and high routing words that the host can write and read back.
// - In the low routing word input i is steered by bits 2i+1:2i for inputs 0 to 6.
// - Code 00 leaves the input off both converter inputs during that stage's conversion.
// - Code 01 connects the input to the converter's negative input.
// - Code 10 connects the input to the converter's positive input.
// - Code 11 ties the input to the bias node, which the host uses for unused inputs.
// - A high routing word per stage steers inputs 7 to 12 the same way from bit 0.
module tsr_stage_regs #(
   parameter logic [11:0] PART_ID = tsr_pkg::PART_ID_DEFAULT
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [9:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   output logic             reg_rvalid,
   input  wire logic [11:0] near_detect,
   output logic      [11:0] stage_near_detect_flag,
   input  wire logic        conv_active,
   input  wire logic [3:0]  conv_stage,
   output logic      [12:0] sense_input_to_neg,
   output logic      [12:0] sense_input_to_pos,
   output logic      [12:0] sense_input_to_bias
);
   // ==================================================================
   // State
   typedef struct packed {
      logic [11:0][13:0] route_low;
      logic [11:0][13:0] route_high;
      logic [11:0]       near;
      logic [15:0]       rdata;
      logic              rvalid;
      logic [12:0]       neg;
      logic [12:0]       pos;
      logic [12:0]       bias;
   } tsr_state_type;

   tsr_state_type state_ff;
   tsr_state_type nxt_state;
   tsr_route_if   rt ();

   // ==================================================================
   // Address decode
   // Returns {hit, high word, stage index}
   function automatic logic [5:0] route_decode(input logic [9:0] addr);
      logic [9:0] rel;
      logic [9:0] idx;
      logic [9:0] sub;
      rel = addr - tsr_pkg::ADDR_ROUTE_BASE;
      idx = rel / tsr_pkg::ROUTE_STRIDE;
      sub = rel % tsr_pkg::ROUTE_STRIDE;
      route_decode = 6'h00;
      if (addr >= tsr_pkg::ADDR_ROUTE_BASE && idx < 10'(tsr_pkg::NUM_STAGES)) begin
         if (sub == tsr_pkg::ROUTE_LOW_SUB) begin
            route_decode = {2'b10, idx[3:0]};
         end else if (sub == tsr_pkg::ROUTE_HIGH_SUB) begin
            route_decode = {2'b11, idx[3:0]};
         end
      end
   endfunction : route_decode

   // ==================================================================
   // Route selection for the converting stage
   assign rt.active    = conv_active && (conv_stage < 4'(tsr_pkg::NUM_STAGES));
   assign rt.word_low  = rt.active ? state_ff.route_low[conv_stage] : tsr_pkg::ROUTE_RESET;
   assign rt.word_high = rt.active ? state_ff.route_high[conv_stage] : tsr_pkg::ROUTE_RESET;

   tsr_route_decode u_decode (
      .rt (rt.decoder)
   );

   // ==================================================================
   // Next state
   always_comb begin
      logic [5:0] wr_hit;
      logic [5:0] rd_hit;
      wr_hit    = route_decode(reg_addr);
      rd_hit    = wr_hit;
      nxt_state = state_ff;
      // Flags follow the detection logic only, never the bus
      nxt_state.near   = near_detect;
      nxt_state.neg    = rt.to_neg;
      nxt_state.pos    = rt.to_pos;
      nxt_state.bias   = rt.to_bias;
      nxt_state.rvalid = reg_rd;
      if (reg_wr && wr_hit[5]) begin
         if (wr_hit[4]) begin
            nxt_state.route_high[wr_hit[3:0]] = reg_wdata[13:0];
         end else begin
            nxt_state.route_low[wr_hit[3:0]] = reg_wdata[13:0];
         end
      end
      if (reg_rd) begin
         if (reg_addr == tsr_pkg::ADDR_DEVICE_IDENTIFICATION) begin
            nxt_state.rdata = {PART_ID, tsr_pkg::REVISION_RESET};
         end else if (reg_addr == tsr_pkg::ADDR_NEAR_FLAGS) begin
            nxt_state.rdata = {4'h0, state_ff.near};
         end else if (rd_hit[5] && rd_hit[4]) begin
            nxt_state.rdata = {2'h0, state_ff.route_high[rd_hit[3:0]]};
         end else if (rd_hit[5]) begin
            nxt_state.rdata = {2'h0, state_ff.route_low[rd_hit[3:0]]};
         end else begin
            nxt_state.rdata = tsr_pkg::RDATA_RESET;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign reg_rdata              = state_ff.rdata;
   assign reg_rvalid             = state_ff.rvalid;
   assign stage_near_detect_flag = state_ff.near;
   assign sense_input_to_neg     = state_ff.neg;
   assign sense_input_to_pos     = state_ff.pos;
   assign sense_input_to_bias    = state_ff.bias;

   // ==================================================================
   // Checks
   a_id_read_value: assert property (@(posedge clock) disable iff (rst)
      reg_rd && reg_addr == tsr_pkg::ADDR_DEVICE_IDENTIFICATION |=> reg_rvalid && reg_rdata == {PART_ID, 4'h0})
      else $error("identification read wrong");

   a_near_flag_track: assert property (@(posedge clock) disable iff (rst)
      !rst |=> stage_near_detect_flag == $past(near_detect) ##1
         (!$past(reg_rd) || $past(reg_addr) != tsr_pkg::ADDR_NEAR_FLAGS ||
          reg_rdata == {4'h0, $past(stage_near_detect_flag)}))
      else $error("proximity flags wrong");

   a_route_readback: assert property (@(posedge clock) disable iff (rst)
      reg_wr && route_decode(reg_addr) >= 6'h20 ##1 reg_rd && !reg_wr && reg_addr == $past(reg_addr)
      |=> reg_rdata == ($past(reg_wdata, 2) & 16'h3fff))
      else $error("routing word readback wrong");

   a_field_six_pos: assert property (@(posedge clock) disable iff (rst)
      rt.active && rt.word_low[13:12] == tsr_pkg::ROUTE_POS |=> sense_input_to_pos[6] && !sense_input_to_neg[6])
      else $error("input six field misplaced");

   a_open_when_idle: assert property (@(posedge clock) disable iff (rst)
      (!conv_active || rt.word_low[1:0] == tsr_pkg::ROUTE_OPEN) |=>
         !sense_input_to_neg[0] && !sense_input_to_pos[0] && !sense_input_to_bias[0])
      else $error("input left connected");

   a_neg_connect: assert property (@(posedge clock) disable iff (rst)
      rt.active && rt.word_low[1:0] == tsr_pkg::ROUTE_NEG |=> sense_input_to_neg[0] && !sense_input_to_pos[0])
      else $error("negative routing wrong");

   a_pos_connect: assert property (@(posedge clock) disable iff (rst)
      rt.active && rt.word_low[3:2] == tsr_pkg::ROUTE_POS |=> sense_input_to_pos[1] && !sense_input_to_bias[1])
      else $error("positive routing wrong");

   a_bias_connect: assert property (@(posedge clock) disable iff (rst)
      rt.active && rt.word_low[1:0] == tsr_pkg::ROUTE_BIAS |=> sense_input_to_bias[0] && !sense_input_to_neg[0])
      else $error("bias routing wrong");

   a_high_word_bias: assert property (@(posedge clock) disable iff (rst)
      rt.active && rt.word_high[1:0] == tsr_pkg::ROUTE_BIAS |=> sense_input_to_bias[7] && !sense_input_to_pos[7])
      else $error("input seven routing wrong");

   a_ro_write_ignored: assert property (@(posedge clock) disable iff (rst)
      reg_wr && (reg_addr == tsr_pkg::ADDR_DEVICE_IDENTIFICATION || reg_addr == tsr_pkg::ADDR_NEAR_FLAGS)
      |=> stage_near_detect_flag == $past(near_detect) && $stable(state_ff.route_low) &&
         $stable(state_ff.route_high))
      else $error("read-only write had effect");

   // ==================================================================
   // Read path checks
   a_rvalid_follow: assert property (@(posedge clock) disable iff (rst)
      reg_rd |=> reg_rvalid)
      else $error("read answer missing");

   a_rvalid_single: assert property (@(posedge clock) disable iff (rst)
      !reg_rd |=> !reg_rvalid)
      else $error("read answer without request");

   a_near_upper_zero: assert property (@(posedge clock) disable iff (rst)
      reg_rd && reg_addr == tsr_pkg::ADDR_NEAR_FLAGS |=> reg_rvalid && reg_rdata[15:12] == 4'h0)
      else $error("proximity upper bits set");

   a_route_upper_zero: assert property (@(posedge clock) disable iff (rst)
      reg_rd && route_decode(reg_addr) >= 6'h20 |=> reg_rdata[15:14] == 2'h0)
      else $error("routing upper bits set");

   // ==================================================================
   // Switch checks
   a_idle_all_open: assert property (@(posedge clock) disable iff (rst)
      !rt.active |=> sense_input_to_neg == 13'h0 && sense_input_to_pos == 13'h0 && sense_input_to_bias == 13'h0)
      else $error("switch closed while idle");

   a_one_path_only: assert property (@(posedge clock) disable iff (rst)
      1'b1 |=> ((sense_input_to_neg & sense_input_to_pos) | (sense_input_to_neg & sense_input_to_bias) |
         (sense_input_to_pos & sense_input_to_bias)) == 13'h0)
      else $error("input on two paths");

   a_input_three_neg: assert property (@(posedge clock) disable iff (rst)
      rt.active && rt.word_low[7:6] == tsr_pkg::ROUTE_NEG |=> sense_input_to_neg[3] && !sense_input_to_pos[3])
      else $error("input three routing wrong");

   a_input_six_bias: assert property (@(posedge clock) disable iff (rst)
      rt.active && rt.word_low[13:12] == tsr_pkg::ROUTE_BIAS |=> sense_input_to_bias[6] && !sense_input_to_pos[6])
      else $error("input six bias wrong");

   a_input_nine_pos: assert property (@(posedge clock) disable iff (rst)
      rt.active && rt.word_high[5:4] == tsr_pkg::ROUTE_POS |=> sense_input_to_pos[9] && !sense_input_to_neg[9])
      else $error("input nine routing wrong");

   a_input_twelve_neg: assert property (@(posedge clock) disable iff (rst)
      rt.active && rt.word_high[11:10] == tsr_pkg::ROUTE_NEG |=> sense_input_to_neg[12] && !sense_input_to_bias[12])
      else $error("input twelve routing wrong");
endmodule : tsr_stage_regs
`default_nettype wire

// ==== tsr_pkg.sv ====
// Shared constants for the stage status and routing register block
`default_nettype none
package tsr_pkg;
   // ==================================================================
   // Register map
   localparam int          ADDR_W          = 10;
   localparam int          DATA_W          = 16;
   localparam int          NUM_STAGES      = 12;
   localparam int          NUM_INPUTS      = 13;
   localparam int          LOW_INPUTS      = 7;
   localparam int          ROUTE_W         = 14;
   localparam logic [9:0]  ADDR_DEVICE_IDENTIFICATION  = 10'h017;
   localparam logic [9:0]  ADDR_NEAR_FLAGS = 10'h042;
   localparam logic [9:0]  ADDR_ROUTE_BASE = 10'h080;
   localparam logic [9:0]  ROUTE_STRIDE    = 10'h008;
   localparam logic [9:0]  ROUTE_LOW_SUB   = 10'h000;
   localparam logic [9:0]  ROUTE_HIGH_SUB  = 10'h001;

   // ==================================================================
   // Identification fields
   localparam logic [3:0]  REVISION_RESET  = 4'h0;
   // Arbitrary neutral part code
   localparam logic [11:0] PART_ID_DEFAULT = 12'h5a3;

   // ==================================================================
   // Reset values and route encodings
   localparam logic [11:0] NEAR_RESET      = 12'h000;
   localparam logic [13:0] ROUTE_RESET     = 14'h0000;
   localparam logic [15:0] RDATA_RESET     = 16'h0000;
   localparam logic [1:0]  ROUTE_OPEN      = 2'h0;
   localparam logic [1:0]  ROUTE_NEG       = 2'h1;
   localparam logic [1:0]  ROUTE_POS       = 2'h2;
   localparam logic [1:0]  ROUTE_BIAS      = 2'h3;
endpackage : tsr_pkg
`default_nettype wire

// ==== tsr_route_if.sv ====
// Carrier between the register bank and the switch decoder
`timescale 1ns/1ps
`default_nettype none
interface tsr_route_if;
   logic        active;
   logic [13:0] word_low;
   logic [13:0] word_high;
   logic [12:0] to_neg;
   logic [12:0] to_pos;
   logic [12:0] to_bias;
   modport bank    (output active, output word_low, output word_high, input to_neg, input to_pos, input to_bias);
   modport decoder (input active, input word_low, input word_high, output to_neg, output to_pos, output to_bias);
endinterface : tsr_route_if
`default_nettype wire

// ==== tsr_route_decode.sv ====
// Decodes the two routing words of the converting stage into switch enables
`timescale 1ns/1ps
`default_nettype none
module tsr_route_decode (
   tsr_route_if.decoder rt
);
   // ==================================================================
   // Field decode
   function automatic logic [2:0] decode_field(input logic [1:0] code);
      // Returns {bias, pos, neg}
      case (code)
         tsr_pkg::ROUTE_NEG:  decode_field = 3'h1;
         tsr_pkg::ROUTE_POS:  decode_field = 3'h2;
         tsr_pkg::ROUTE_BIAS: decode_field = 3'h4;
         default:             decode_field = 3'h0;
      endcase
   endfunction : decode_field

   always_comb begin
      logic [2:0]  sw;
      logic [25:0] codes;
      sw    = 3'h0;
      codes = {rt.word_high[11:0], rt.word_low};
      for (int i = 0; i < tsr_pkg::NUM_INPUTS; i++) begin
         sw = rt.active ? decode_field(codes[2*i +: 2]) : 3'h0;
         rt.to_neg[i]  = sw[0];
         rt.to_pos[i]  = sw[1];
         rt.to_bias[i] = sw[2];
      end
   end
endmodule : tsr_route_decode
`default_nettype wire

// ==== tsr_stage_regs_note_end.sv ====
// Empty unit that holds no logic
`default_nettype none
`default_nettype wire

// ==== tsr_host_model.sv ====
// Host processor model driving the register strobe protocol
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model (
   input  wire logic        clock,
   output logic      [9:0]  reg_addr,
   output logic      [15:0] reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rvalid
);
   initial begin
      reg_addr = 10'h000;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // ===============================
   // Bus cycles
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [15:0] q, output logic v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      q = reg_rdata;
      v = reg_rvalid;
   endtask : rd

   // Write then read the same address on the next cycle
   task automatic wr_rd(input logic [9:0] a, input logic [15:0] d, output logic [15:0] q, output logic v);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      reg_wdata <= ~d;
      @(posedge clock);
      reg_rd    <= 1'b0;
      reg_addr  <= ~a;
      #1;
      q = reg_rdata;
      v = reg_rvalid;
   endtask : wr_rd
endmodule : tsr_host_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the stage status and routing registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
   logic        clock, rst, reg_wr, reg_rd, reg_rvalid, conv_active, v;
   logic [9:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, q;
   logic [11:0] near_detect, stage_near_detect_flag;
   logic [3:0]  conv_stage;
   logic [12:0] to_neg, to_pos, to_bias;
   int          failures = 0, total_checks = 0, cycles = 0;

   tsr_stage_regs DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .near_detect(near_detect),
      .stage_near_detect_flag(stage_near_detect_flag), .conv_active(conv_active), .conv_stage(conv_stage),
      .sense_input_to_neg(to_neg), .sense_input_to_pos(to_pos), .sense_input_to_bias(to_bias));
   tsr_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         failures++;
         print_verdict();
      end
   end

   // ===============================
   // Helpers
   task automatic print_verdict();
      $display("Checks %0d, errors %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict

   // Code of input i is (i+s+k) mod 4, so every input sees every code
   function automatic logic [13:0] mk(input int s, input int k);
      logic [13:0] r;
      for (int i = 0; i < 7; i++) r[2*i+:2] = 2'((i + s + k) % 4);
      return r;
   endfunction : mk

   function automatic logic [38:0] exp_sw(input logic [13:0] lo, input logic [13:0] hi);
      logic [1:0]  c;
      logic [38:0] r;
      for (int i = 0; i < 13; i++) begin
         c = (i < 7) ? lo[2*i+:2] : hi[2*(i-7)+:2];
         r[26+i] = (c === tsr_pkg::ROUTE_NEG);
         r[13+i] = (c === tsr_pkg::ROUTE_POS);
         r[i] = (c === tsr_pkg::ROUTE_BIAS);
      end
      return r;
   endfunction : exp_sw

   function automatic logic [9:0] ra(input int s, input logic [9:0] sub);
      return tsr_pkg::ADDR_ROUTE_BASE + tsr_pkg::ROUTE_STRIDE * 10'(s) + sub;
   endfunction : ra

   task automatic chk_rd(input logic [9:0] a, input logic [15:0] e);
      host.rd(a, q, v);
      `CHK(v, 1'b1)
      `CHK(q, e)
   endtask : chk_rd

   task automatic route_chk(input logic act, input int st, input logic [13:0] lo, input logic [13:0] hi);
      @(posedge clock);
      conv_active <= act;
      conv_stage  <= 4'(st);
      @(posedge clock);
      #1;
      `CHK({to_neg, to_pos, to_bias}, (act && st < tsr_pkg::NUM_STAGES) ? exp_sw(lo, hi) : 39'h0)
   endtask : route_chk

   // ===============================
   // Test sequence
   initial begin
      rst = 1'b1;
      near_detect = 12'h000;
      conv_active = 1'b0;
      conv_stage = 4'h0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      route_chk(1'b1, 0, 14'h0000, 14'h0000);
      chk_rd(tsr_pkg::ADDR_DEVICE_IDENTIFICATION, {tsr_pkg::PART_ID_DEFAULT, tsr_pkg::REVISION_RESET});
      chk_rd(tsr_pkg::ADDR_NEAR_FLAGS, 16'h0000);
      @(posedge clock);
      near_detect <= 12'ha5c;
      @(posedge clock);
      #1;
      `CHK(stage_near_detect_flag, 12'ha5c)
      host.wr(tsr_pkg::ADDR_DEVICE_IDENTIFICATION, 16'hffff);
      host.wr(tsr_pkg::ADDR_NEAR_FLAGS, 16'h0000);
      chk_rd(tsr_pkg::ADDR_DEVICE_IDENTIFICATION, {tsr_pkg::PART_ID_DEFAULT, tsr_pkg::REVISION_RESET});
      chk_rd(tsr_pkg::ADDR_NEAR_FLAGS, 16'h0a5c);
      for (int s = 0; s < 12; s++) begin
         host.wr(ra(s, tsr_pkg::ROUTE_LOW_SUB), {2'b00, mk(s, 0)});
         host.wr(ra(s, tsr_pkg::ROUTE_HIGH_SUB), {2'b00, mk(s, 1)});
      end
      for (int s = 0; s < 12; s++) begin
         chk_rd(ra(s, tsr_pkg::ROUTE_LOW_SUB), {2'b00, mk(s, 0)});
         chk_rd(ra(s, tsr_pkg::ROUTE_HIGH_SUB), {2'b00, mk(s, 1)});
         route_chk(1'b1, s, mk(s, 0), mk(s, 1));
      end
      host.wr(ra(0, tsr_pkg::ROUTE_LOW_SUB), {2'b11, mk(0, 0)});
      chk_rd(ra(0, tsr_pkg::ROUTE_LOW_SUB), {2'b00, mk(0, 0)});
      host.wr(ra(0, 10'h002), 16'h1234);
      chk_rd(ra(0, 10'h002), 16'h0000);
      host.wr_rd(ra(7, tsr_pkg::ROUTE_HIGH_SUB), 16'hf2d5, q, v);
      `CHK(v, 1'b1)
      `CHK(q, 16'h32d5)
      route_chk(1'b0, 3, mk(3, 0), mk(3, 1));
      route_chk(1'b1, 12, 14'h0000, 14'h0000);
      // Reset in mid-run clears routing, flags reload from detection
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      route_chk(1'b1, 4, 14'h0000, 14'h0000);
      chk_rd(ra(4, tsr_pkg::ROUTE_LOW_SUB), 16'h0000);
      chk_rd(tsr_pkg::ADDR_NEAR_FLAGS, 16'h0a5c);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
